// File: core/lfs_defines.vh
// Overview of operation
// - field strobe pin: driven by us in master mode, input in slave mode.
// - line strobe pin: driven by us in master mode, input in slave mode.
// - slave mode aligns all internal timing to incoming line and field strobes.
// - resync pulse clears counters and restarts strobe outputs aligned to it.
// - all timing derives from the single master clock input.
// - horizontal and vertical counters locate every pixel and line position.
// - horizontal counter supports lines up to 8192 pixel clocks.
// - vertical counter supports fields up to 4096 lines.
`ifndef LFS_DEFINES_VH
`define LFS_DEFINES_VH
`define LFS_H_MAX        8192
`define LFS_V_MAX        4096
`define LFS_H_WIDTH      13
`define LFS_V_WIDTH      12
`define LFS_H_RESET      13'h0000
`define LFS_V_RESET      12'h000
`define LFS_LINE_DEF     13'h0100
`define LFS_FIELD_DEF    12'h0010
`define LFS_LPULSE_DEF   13'h0004
`define LFS_FPULSE_DEF   12'h001
`endif

// File: core/lfs_edge_detect.v
`timescale 1ns/100ps
`include "lfs_defines.vh"
module lfs_edge_detect (
  input  wire CORE_CLK,
  input  wire RST,
  input  wire level_in,
  output wire fall
);
  reg prev;
  // strobes are active low, so a falling edge marks the start
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      prev <= 1'b1;
    end else begin
      prev <= level_in;
    end
  end
  assign fall = prev & ~level_in;
endmodule

// File: core/lfs_sync_counters.v
`timescale 1ns/100ps
`include "lfs_defines.vh"
module lfs_sync_counters #(
  parameter H_WIDTH = `LFS_H_WIDTH,
  parameter V_WIDTH = `LFS_V_WIDTH
) (
  input  wire               CORE_CLK,
  input  wire               RST,
  input  wire               MASTER_MODE,
  input  wire               RESYNC,
  input  wire [H_WIDTH-1:0] LINE_LENGTH,
  input  wire [V_WIDTH-1:0] FIELD_LENGTH,
  input  wire [H_WIDTH-1:0] LINE_PULSE_WIDTH,
  input  wire [V_WIDTH-1:0] FIELD_PULSE_WIDTH,
  input  wire               LINE_STROBE_N_I,
  output reg                LINE_STROBE_N_O,
  output wire               LINE_STROBE_OE,
  input  wire               FIELD_STROBE_N_I,
  output reg                FIELD_STROBE_N_O,
  output wire               FIELD_STROBE_OE,
  output reg  [H_WIDTH-1:0] H_COUNT,
  output reg  [V_WIDTH-1:0] V_COUNT,
  output reg                LINE_START,
  output reg                FIELD_START
);
  ////////////////////////////////////////////////////////////////////////////
  wire               line_fall;
  wire               field_fall;
  reg                resync_d;
  wire               resync_pulse;
  reg  [H_WIDTH-1:0] next_h;
  reg  [V_WIDTH-1:0] next_v;
  reg                next_line_start;
  reg                next_field_start;
  wire               h_wrap;
  wire               v_wrap;
  wire [H_WIDTH-1:0] h_last;
  wire [V_WIDTH-1:0] v_last;

  // terminal count compare is shared by both counters
  function at_end;
    input [15:0] count;
    input [15:0] last;
    begin
      at_end = (count >= last);
    end
  endfunction

  // pins are outputs only in master mode
  assign LINE_STROBE_OE  = MASTER_MODE;
  assign FIELD_STROBE_OE = MASTER_MODE;

  lfs_edge_detect u_line_edge (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .level_in (LINE_STROBE_N_I),
    .fall     (line_fall)
  );

  lfs_edge_detect u_field_edge (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .level_in (FIELD_STROBE_N_I),
    .fall     (field_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // resync is edge triggered so a long pulse restarts the frame only once
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      resync_d <= 1'b0;
    end else begin
      resync_d <= RESYNC;
    end
  end
  assign resync_pulse = RESYNC & ~resync_d;

  // a zero length means full range: subtracting in port width lands on the top count
  assign h_last = LINE_LENGTH - {{(H_WIDTH-1){1'b0}}, 1'b1};
  assign v_last = FIELD_LENGTH - {{(V_WIDTH-1){1'b0}}, 1'b1};
  assign h_wrap = at_end({{(16-H_WIDTH){1'b0}}, H_COUNT}, {{(16-H_WIDTH){1'b0}}, h_last});
  assign v_wrap = at_end({{(16-V_WIDTH){1'b0}}, V_COUNT}, {{(16-V_WIDTH){1'b0}}, v_last});

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    next_h           = H_COUNT + {{(H_WIDTH-1){1'b0}}, 1'b1};
    next_v           = V_COUNT;
    next_line_start  = 1'b0;
    next_field_start = 1'b0;
    if (resync_pulse) begin
      next_h           = {H_WIDTH{1'b0}};
      next_v           = {V_WIDTH{1'b0}};
      next_line_start  = 1'b1;
      next_field_start = 1'b1;
    end else if (!MASTER_MODE) begin
      // slave: counters follow the incoming strobe edges
      if (field_fall) begin
        next_h           = {H_WIDTH{1'b0}};
        next_v           = {V_WIDTH{1'b0}};
        next_line_start  = 1'b1;
        next_field_start = 1'b1;
      end else if (line_fall) begin
        next_h          = {H_WIDTH{1'b0}};
        next_v          = V_COUNT + {{(V_WIDTH-1){1'b0}}, 1'b1};
        next_line_start = 1'b1;
      end else if (H_COUNT == {H_WIDTH{1'b1}}) begin
        // hold at the top rather than alias into the next line
        next_h = H_COUNT;
      end
    end else if (h_wrap) begin
      next_h          = {H_WIDTH{1'b0}};
      next_line_start = 1'b1;
      if (v_wrap) begin
        next_v           = {V_WIDTH{1'b0}};
        next_field_start = 1'b1;
      end else begin
        next_v = V_COUNT + {{(V_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single clock domain: everything steps on the master clock
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      H_COUNT          <= `LFS_H_RESET;
      V_COUNT          <= `LFS_V_RESET;
      LINE_START       <= 1'b0;
      FIELD_START      <= 1'b0;
      LINE_STROBE_N_O  <= 1'b1;
      FIELD_STROBE_N_O <= 1'b1;
    end else begin
      H_COUNT          <= next_h;
      V_COUNT          <= next_v;
      LINE_START       <= next_line_start;
      FIELD_START      <= next_field_start;
      // strobes low for the first pulse-width counts of each line/field
      LINE_STROBE_N_O  <= ~(MASTER_MODE & (next_h < LINE_PULSE_WIDTH));
      FIELD_STROBE_N_O <= ~(MASTER_MODE & (next_v < FIELD_PULSE_WIDTH));
    end
  end
endmodule

// File: verif/lfs_checker.sv
`timescale 1ns/100ps
module lfs_checker (
  input wire        CORE_CLK,
  input wire        RST,
  input wire        MASTER_MODE,
  input wire        RESYNC,
  input wire [12:0] LINE_LENGTH,
  input wire [11:0] FIELD_LENGTH,
  input wire [12:0] LINE_PULSE_WIDTH,
  input wire [11:0] FIELD_PULSE_WIDTH,
  input wire        LINE_STROBE_N_O,
  input wire        FIELD_STROBE_N_O,
  input wire        LINE_STROBE_OE,
  input wire        FIELD_STROBE_OE,
  input wire [12:0] H_COUNT,
  input wire [11:0] V_COUNT,
  input wire        LINE_START,
  input wire        FIELD_START
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // resync is left out: its restart outranks every count step
  sequence run;
    MASTER_MODE && !RESYNC;
  endsequence
  sequence line_end;
    run ##0 H_COUNT == LINE_LENGTH - 13'h0001;
  endsequence
  //////////////////////////////
  oe_line_a: assert property (LINE_STROBE_OE == MASTER_MODE) else $error("line oe");
  oe_field_a: assert property (FIELD_STROBE_OE == MASTER_MODE) else $error("field oe");
  h_step_a: assert property (run ##0 H_COUNT != LINE_LENGTH - 13'h0001
    |=> H_COUNT == $past(H_COUNT) + 13'h0001) else $error("h");
  h_wrap_a: assert property (line_end |=> H_COUNT == 13'h0000 && LINE_START) else $error("h wrap");
  v_step_a: assert property (line_end ##0 V_COUNT != FIELD_LENGTH - 12'h001 |=> V_COUNT == $past(V_COUNT) + 12'h001) else $error("v");
  v_wrap_a: assert property (line_end ##0 V_COUNT == FIELD_LENGTH - 12'h001 |=> !V_COUNT && FIELD_START) else $error("v wrap");
  // the first edge after reset still shows the reset level of the strobe
  line_strobe_a: assert property (MASTER_MODE && !$past(RST)
    |-> LINE_STROBE_N_O == (H_COUNT >= LINE_PULSE_WIDTH)) else $error("line strobe");
  field_strobe_a: assert property (MASTER_MODE && !$past(RST)
    |-> FIELD_STROBE_N_O == (V_COUNT >= FIELD_PULSE_WIDTH)) else $error("field strobe");
  resync_restart_a: assert property ($rose(RESYNC)
    |-> ##1 !H_COUNT && !V_COUNT && LINE_START && FIELD_START) else $error("resync");
endmodule
bind lfs_sync_counters lfs_checker chk_u (.CORE_CLK, .RST, .MASTER_MODE, .RESYNC, .LINE_LENGTH, .FIELD_LENGTH,
  .LINE_PULSE_WIDTH, .FIELD_PULSE_WIDTH, .LINE_STROBE_N_O, .FIELD_STROBE_N_O, .LINE_STROBE_OE, .FIELD_STROBE_OE,
  .H_COUNT, .V_COUNT, .LINE_START, .FIELD_START);

// File: verif/lfs_proc_model.sv
`timescale 1ns/100ps
module lfs_proc_model (
  input  wire clk,
  input  wire drive,
  output reg  line_n = 1'b1,
  output reg  field_n = 1'b1
);
  integer p = 0;
  integer l = 0;
  // released strobes read high, as the pull-up would leave them
  always @(negedge clk) begin
    p = drive ? (p + 1) % 5 : 0;
    if (drive && p == 0) l = (l + 1) % 3;
    line_n <= !(drive && p == 0);
    field_n <= !(drive && p == 0 && l == 0);
  end
endmodule

// File: verif/lfs_sync_counters_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t mismatch", $time); end end
module lfs_sync_counters_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         mode = 1'b1;
  reg         resync = 1'b0;
  reg  [12:0] len = 13'h0004;
  reg  [11:0] flen = 12'h003;
  wire        lo, loe, fo, foe, lm, fm, ls, fs;
  wire [12:0] h;
  wire [11:0] v;
  integer     n_fail = 0;
  integer     checks = 0;
  integer     i;
  always #50 clk = ~clk;
  lfs_sync_counters dut_u (.CORE_CLK(clk), .RST(rst), .MASTER_MODE(mode), .RESYNC(resync), .LINE_LENGTH(len),
    .FIELD_LENGTH(flen), .LINE_PULSE_WIDTH(13'h0001), .FIELD_PULSE_WIDTH(12'h001), .LINE_STROBE_N_I(loe ? lo : lm),
    .LINE_STROBE_N_O(lo), .LINE_STROBE_OE(loe), .FIELD_STROBE_N_I(foe ? fo : fm), .FIELD_STROBE_N_O(fo),
    .FIELD_STROBE_OE(foe), .H_COUNT(h), .V_COUNT(v), .LINE_START(ls), .FIELD_START(fs));
  lfs_proc_model pm_u (.clk(clk), .drive(!mode && !rst), .line_n(lm), .field_n(fm));
  //////////////////////////////
  task start(input m, input [12:0] l, input [11:0] f);
    rst = 1'b1;
    mode = m;
    len = l;
    flen = f;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask
  task t_count(input [12:0] l, input [11:0] f, input integer n);
    start(1'b1, l, f);
    for (i = 1; i <= n; i++) begin
      @(negedge clk);
      `CHK({h, v}, {13'(i % (l ? l : 8192)), 12'(i / (l ? l : 8192) % (f ? f : 4096))})
    end
  endtask
  task t_resync;
    start(1'b1, 13'h0004, 12'h003);
    repeat (6) @(negedge clk);
    resync = 1'b1;
    @(negedge clk);
    `CHK({h, v, ls, fs, lo}, 28'h000_0006)
    @(negedge clk);
    `CHK(h, 13'h0001)
    resync = 1'b0;
  endtask
  task t_slave;
    start(1'b0, 13'h0000, 12'h000);
    `CHK({loe, foe}, 2'h0)
    for (i = 0; i < 40 && fs !== 1'b1; i++) @(negedge clk);
    `CHK(fs, 1'b1)
    for (i = 0; i < 15; i++) begin
      `CHK({h, v}, {13'(i % 5), 12'(i / 5)})
      @(negedge clk);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_count(13'h0004, 12'h003, 30);
    t_count(13'h0000, 12'h002, 8200);
    t_count(13'h0002, 12'h000, 8200);
    t_resync;
    t_slave;
    stop_test;
  end
  // a full run is about 17k cycles
  initial begin
    #3000000;
    n_fail++;
    stop_test;
  end
endmodule
